// ---- core/fic_pkg.sv ----
// constants, types and register map of the queue, pin and filter settings
package fic_pkg;

  // ===========================================================
  // register map
  localparam logic [7:0] FIC_ADDR_QUEUE_SETUP  = 8'h28;
  localparam logic [7:0] FIC_ADDR_SAMPLE_THR   = 8'h29;
  localparam logic [7:0] FIC_ADDR_PIN1_ROUTE   = 8'h2A;
  localparam logic [7:0] FIC_ADDR_PIN2_ROUTE   = 8'h2B;
  localparam logic [7:0] FIC_ADDR_RATE_FILTER  = 8'h2C;
  localparam logic [7:0] FIC_UNMAPPED_DATA     = 8'h00;

  // ===========================================================
  // reset values
  localparam logic [7:0] FIC_RST_QUEUE_SETUP   = 8'h00;
  localparam logic [7:0] FIC_RST_SAMPLE_THR    = 8'h80;
  localparam logic [7:0] FIC_RST_PIN_ROUTE     = 8'h00;
  localparam logic [7:0] FIC_RST_RATE_FILTER   = 8'h13;

  // ===========================================================
  // field positions
  localparam int FIC_QS_MODE_LSB     = 0;   // queue mode [1:0]
  localparam int FIC_QS_STORE_TEMP   = 2;
  localparam int FIC_QS_COUNT_TOP    = 3;   // sample_count_top_bit
  localparam int FIC_PR_ACTIVE_LOW   = 7;
  localparam int FIC_NUM_COND        = 7;   // routed conditions [6:0]
  localparam int FIC_COND_NEW_SAMPLE = 0;
  localparam int FIC_COND_Q_AVAIL    = 1;
  localparam int FIC_COND_Q_WMARK    = 2;
  localparam int FIC_COND_Q_OVERRUN  = 3;
  localparam int FIC_COND_MOTION     = 4;   // motion_event
  localparam int FIC_COND_STILLNESS  = 5;   // stillness_event
  localparam int FIC_COND_AWAKE      = 6;
  localparam int FIC_RF_RATE_LSB     = 0;   // output_rate_select [2:0]
  localparam int FIC_RF_EXT_TRIG     = 3;   // external_trigger_sampling
  localparam int FIC_RF_QUARTER_BW   = 4;   // quarter_rate_filter
  localparam int FIC_RF_RANGE_LSB    = 6;   // range [7:6]
  localparam int FIC_NUM_PINS        = 2;
  localparam logic [2:0] FIC_RATE_CODE_MAX = 3'h5; // 101..111 all top rate

  // ===========================================================
  // decoded settings
  typedef enum logic [1:0] {
    FIC_Q_OFF, FIC_Q_OLDEST, FIC_Q_STREAM, FIC_Q_TRIGGERED
  } fic_qmode_e;

  typedef enum logic [1:0] {
    FIC_RANGE_2G, FIC_RANGE_4G, FIC_RANGE_8G
  } fic_range_e;

  typedef enum logic [2:0] {
    FIC_RATE_12HZ5, FIC_RATE_25HZ, FIC_RATE_50HZ,
    FIC_RATE_100HZ, FIC_RATE_200HZ, FIC_RATE_400HZ
  } fic_rate_e;

  typedef struct packed {
    fic_qmode_e  queue_mode;
    logic        store_temperature;
    logic [8:0]  sample_threshold;
    fic_range_e  range;
    logic        quarter_rate_filter;
    logic        external_trigger_sampling;
    fic_rate_e   output_rate_select;
  } fic_cfg_s;

endpackage

// ---- core/fic_pin_drv.sv ----
// one interrupt pin: condition routing, or-combining, polarity and release
`timescale 1ns/1ps
module fic_pin_drv
  import fic_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic [7:0]              i_route,
  input  wire logic [FIC_NUM_COND-1:0] i_cond,
  input  wire logic                    i_release,
  output logic                         o_pin_o,
  output logic                         o_pin_oe,
  output logic                         o_asserted
);

  // ===========================================================
  // combining
  logic routed;
  logic hit;

  // any routed condition asserts the pin
  assign routed     = |i_route[FIC_NUM_COND-1:0];
  assign hit        = |(i_route[FIC_NUM_COND-1:0] & i_cond);
  assign o_asserted = hit;

  // ===========================================================
  // pin drive
  // level only moves while driven, so the keeper sees a stable last level
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pin_o  <= 1'b0;
      o_pin_oe <= 1'b0;
    end
    else
    begin
      o_pin_oe <= routed & ~i_release;
      if (routed & ~i_release)
        o_pin_o <= hit ^ i_route[FIC_PR_ACTIVE_LOW];
    end
  end

endmodule // fic_pin_drv

// ---- core/fic_regs.sv ----
// queue, interrupt pin routing and rate/range/filter setting registers
//
// Functional notes
// - queue mode selects off/oldest/stream/triggered
// - temperature bit stores temperature in queue
// - bit 3 is sample count top bit
// - nine-bit count sets queue watermark level
// - sample count register resets to 0x80
// - low seven routing bits map conditions
// - routing bit 7 set makes pin active-low
// - routed conditions are OR-combined per pin
// - nothing routed leaves pin undriven
// - fixed condition positions, same both pins
// - each condition readable regardless of routing
// - range field selects 2, 4, 8 g
// - quarter-rate filter bit, resets set
// - external trigger takes timing from second pin
// - rate field selects 12.5 to 400 Hz
`timescale 1ns/1ps
module fic_regs
  import fic_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_reg_wr,
  input  wire logic [7:0]              i_reg_addr,
  input  wire logic [7:0]              i_reg_wdata,
  output logic [7:0]                   o_reg_rdata,
  input  wire logic [FIC_NUM_COND-1:0] i_cond,
  input  wire logic [9:0]              i_queue_level,
  input  wire logic                    i_second_interrupt_pin_i,
  output logic                         o_first_interrupt_pin_o,
  output logic                         o_first_interrupt_pin_oe,
  output logic                         o_second_interrupt_pin_o,
  output logic                         o_second_interrupt_pin_oe,
  output logic [FIC_NUM_COND-1:0]      o_cond_status,
  output logic                         o_watermark,
  output logic                         o_conversion_trigger,
  output fic_cfg_s                     o_cfg
);

  // ===========================================================
  // register storage
  logic [7:0] queue_setup_q;
  logic [7:0] sample_thr_q;
  logic [7:0] route_q [FIC_NUM_PINS];
  logic [7:0] rate_filter_q;
  logic       ext_pin_q;
  logic [FIC_NUM_PINS-1:0] pin_o;
  logic [FIC_NUM_PINS-1:0] pin_oe;
  logic [FIC_NUM_PINS-1:0] pin_hit;
  logic       ext_trig;
  logic [8:0] thr;

  // host writes land at the next edge; all bits are stored as written
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      queue_setup_q <= FIC_RST_QUEUE_SETUP;
      sample_thr_q  <= FIC_RST_SAMPLE_THR;
      route_q[0]    <= FIC_RST_PIN_ROUTE;
      route_q[1]    <= FIC_RST_PIN_ROUTE;
      rate_filter_q <= FIC_RST_RATE_FILTER;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        FIC_ADDR_QUEUE_SETUP: queue_setup_q <= i_reg_wdata;
        FIC_ADDR_SAMPLE_THR:  sample_thr_q  <= i_reg_wdata;
        FIC_ADDR_PIN1_ROUTE:  route_q[0]    <= i_reg_wdata;
        FIC_ADDR_PIN2_ROUTE:  route_q[1]    <= i_reg_wdata;
        FIC_ADDR_RATE_FILTER: rate_filter_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ===========================================================
  // read port
  // one-cycle latency keeps read data on flip-flops
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= FIC_UNMAPPED_DATA;
    else
    begin
      case (i_reg_addr)
        FIC_ADDR_QUEUE_SETUP: o_reg_rdata <= queue_setup_q;
        FIC_ADDR_SAMPLE_THR:  o_reg_rdata <= sample_thr_q;
        FIC_ADDR_PIN1_ROUTE:  o_reg_rdata <= route_q[0];
        FIC_ADDR_PIN2_ROUTE:  o_reg_rdata <= route_q[1];
        FIC_ADDR_RATE_FILTER: o_reg_rdata <= rate_filter_q;
        default:              o_reg_rdata <= FIC_UNMAPPED_DATA;
      endcase
    end
  end

  // ===========================================================
  // decoded settings
  assign thr = {queue_setup_q[FIC_QS_COUNT_TOP], sample_thr_q};

  always_comb
  begin
    o_cfg.queue_mode = fic_qmode_e'(queue_setup_q[FIC_QS_MODE_LSB +: 2]);
    o_cfg.store_temperature = queue_setup_q[FIC_QS_STORE_TEMP];
    o_cfg.sample_threshold  = thr;
    case (rate_filter_q[FIC_RF_RANGE_LSB +: 2])
      2'h0:    o_cfg.range = FIC_RANGE_2G;
      2'h1:    o_cfg.range = FIC_RANGE_4G;
      default: o_cfg.range = FIC_RANGE_8G;
    endcase
    o_cfg.quarter_rate_filter = rate_filter_q[FIC_RF_QUARTER_BW];
    o_cfg.external_trigger_sampling = rate_filter_q[FIC_RF_EXT_TRIG];
    // codes above the top rate saturate rather than wrap
    if (rate_filter_q[FIC_RF_RATE_LSB +: 3] > FIC_RATE_CODE_MAX)
      o_cfg.output_rate_select = FIC_RATE_400HZ;
    else
      o_cfg.output_rate_select =
        fic_rate_e'(rate_filter_q[FIC_RF_RATE_LSB +: 3]);
  end

  // ===========================================================
  // watermark and status
  // watermark is held off while the queue is disabled
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_watermark   <= 1'b0;
      o_cond_status <= '0;
    end
    else
    begin
      o_watermark   <= (o_cfg.queue_mode != FIC_Q_OFF) &&
                       (i_queue_level >= {1'b0, thr});
      o_cond_status <= i_cond;
    end
  end

  // ===========================================================
  // external conversion trigger on the second pin
  // pin input sampled every cycle; trigger only raised while the pin is released to the outside
  assign ext_trig = rate_filter_q[FIC_RF_EXT_TRIG];

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ext_pin_q            <= 1'b0;
      o_conversion_trigger <= 1'b0;
    end
    else
    begin
      ext_pin_q            <= i_second_interrupt_pin_i;
      o_conversion_trigger <= ext_trig & i_second_interrupt_pin_i &
                              ~ext_pin_q;
    end
  end

  // ===========================================================
  // interrupt pins, same condition layout on both
  generate
    for (genvar p = 0; p < FIC_NUM_PINS; p++)
    begin : g_pin
      fic_pin_drv u_drv (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_route    (route_q[p]),
        .i_cond     (i_cond),
        .i_release  ((p == 1) ? ext_trig : 1'b0),
        .o_pin_o    (pin_o[p]),
        .o_pin_oe   (pin_oe[p]),
        .o_asserted (pin_hit[p])
      );
    end
  endgenerate

  assign o_first_interrupt_pin_o   = pin_o[0];
  assign o_first_interrupt_pin_oe  = pin_oe[0];
  assign o_second_interrupt_pin_o  = pin_o[1];
  assign o_second_interrupt_pin_oe = pin_oe[1];

  // ===========================================================
  // checks
  property p_write_lands;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == FIC_ADDR_PIN1_ROUTE) |=>
      route_q[0] == $past(i_reg_wdata);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("routing write not stored");

  property p_readback;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == FIC_ADDR_QUEUE_SETUP ##1
     !i_reg_wr && i_reg_addr == FIC_ADDR_QUEUE_SETUP) |=>
      o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("queue setup readback mismatch");

  property p_watermark;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (queue_setup_q[1:0] != 2'h0 && i_queue_level >= {1'b0, thr}) |=>
      o_watermark;
  endproperty
  a_watermark: assert property (p_watermark)
    else $error("watermark missed");

  property p_wm_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (queue_setup_q[1:0] == 2'h0) |=> !o_watermark;
  endproperty
  a_wm_off: assert property (p_wm_off)
    else $error("watermark while queue off");

  property p_pin_level;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (|route_q[0][6:0]) |=>
      o_first_interrupt_pin_oe &&
      o_first_interrupt_pin_o ==
        ($past(|(route_q[0][6:0] & i_cond)) ^ $past(route_q[0][7]));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("first pin level wrong");

  property p_released;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (route_q[1][6:0] == 7'h00) |=>
      !o_second_interrupt_pin_oe && $stable(o_second_interrupt_pin_o);
  endproperty
  a_released: assert property (p_released)
    else $error("unrouted pin driven");

  property p_ext_release;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ext_trig |=> !o_second_interrupt_pin_oe;
  endproperty
  a_ext_release: assert property (p_ext_release)
    else $error("second pin driven in trigger mode");

  property p_range;
    @(posedge i_mclk) disable iff (!i_rst_n)
    rate_filter_q[7] |-> o_cfg.range == FIC_RANGE_8G;
  endproperty
  a_range: assert property (p_range)
    else $error("range decode wrong");

  property p_rate_sat;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rate_filter_q[2:0] >= 3'h5) |-> o_cfg.output_rate_select ==
      FIC_RATE_400HZ;
  endproperty
  a_rate_sat: assert property (p_rate_sat)
    else $error("rate code not saturated");

  property p_status;
    @(posedge i_mclk) disable iff (!i_rst_n)
    1'b1 |=> o_cond_status == $past(i_cond);
  endproperty
  a_status: assert property (p_status)
    else $error("status does not follow conditions");

  // a queue setup write reaches the decoded settings one edge later
  property p_queue_fields;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == FIC_ADDR_QUEUE_SETUP) |=>
      o_cfg.queue_mode == $past(i_reg_wdata[1:0]) &&
      o_cfg.store_temperature == $past(i_reg_wdata[2]) &&
      o_cfg.sample_threshold[8] == $past(i_reg_wdata[3]);
  endproperty
  a_queue_fields: assert property (p_queue_fields)
    else $error("queue setup fields not decoded");

  property p_filter_fields;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == FIC_ADDR_RATE_FILTER) |=>
      o_cfg.quarter_rate_filter == $past(i_reg_wdata[4]) &&
      o_cfg.external_trigger_sampling == $past(i_reg_wdata[3]);
  endproperty
  a_filter_fields: assert property (p_filter_fields)
    else $error("filter fields not decoded");

  // second pin follows the same layout unless given to the trigger
  property p_pin2_level;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (|route_q[1][6:0] && !ext_trig) |=>
      o_second_interrupt_pin_oe &&
      o_second_interrupt_pin_o ==
        ($past(|(route_q[1][6:0] & i_cond)) ^ $past(route_q[1][7]));
  endproperty
  a_pin2_level: assert property (p_pin2_level)
    else $error("second pin level wrong");

  property p_trig_pulse;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_conversion_trigger |=> !o_conversion_trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("conversion trigger longer than one cycle");

  property p_unmapped_read;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_reg_addr < FIC_ADDR_QUEUE_SETUP || i_reg_addr > FIC_ADDR_RATE_FILTER)
      |=> o_reg_rdata == FIC_UNMAPPED_DATA;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  c_pin_low: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    route_q[0][7] && o_first_interrupt_pin_oe && !o_first_interrupt_pin_o);
  c_wm: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_watermark));
  c_trig: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_conversion_trigger);
  c_both: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    pin_hit == 2'h3);

endmodule // fic_regs

// ---- testbench/fic_pin_keeper.sv ----
// far-side model of one interrupt pin wire: bus keeper and trigger source
`timescale 1ns/1ps
module fic_pin_keeper
(
  input  wire logic i_pin_o,
  input  wire logic i_pin_oe,
  input  wire logic i_ext,
  input  wire logic i_ext_en,
  output logic      o_wire
);
  // ==========================================================
  // wire level
  // keeper holds the last driven level while nobody drives
  logic kept = 1'b0;
  always @*
  begin
    if (i_pin_oe)
      kept = i_pin_o;
    else if (i_ext_en)
      kept = i_ext;
  end
  assign o_wire = kept;
endmodule // fic_pin_keeper

// ---- testbench/fifo_intmap_filter_config_tb.sv ----
// self-checking bench of the queue, pin routing and filter registers
`timescale 1ns/1ps
module fifo_intmap_filter_config_tb;
  import fic_pkg::*;
  typedef struct {int sel; logic [18:0] exp;} fic_note_s;
  // ==========================================================
  // signals
  logic       i_mclk, i_rst_n, i_reg_wr, ext_drv, o1, oe1, o2, oe2;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [6:0] i_cond, o_cond_status;
  logic [9:0] i_queue_level;
  logic       o_watermark, o_conversion_trigger, l1, l2;
  wire        pin2_in, lvl1;
  fic_cfg_s   o_cfg;
  fic_note_s  pend[$];
  logic [7:0] sh[5];
  int         failures, check_count, k;
  event       look;
  fic_regs DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_cond(i_cond),
    .i_queue_level(i_queue_level), .i_second_interrupt_pin_i(pin2_in),
    .o_first_interrupt_pin_o(o1), .o_first_interrupt_pin_oe(oe1),
    .o_second_interrupt_pin_o(o2), .o_second_interrupt_pin_oe(oe2),
    .o_cond_status(o_cond_status), .o_watermark(o_watermark),
    .o_conversion_trigger(o_conversion_trigger), .o_cfg(o_cfg));
  fic_pin_keeper k1 (.i_pin_o(o1), .i_pin_oe(oe1), .i_ext(1'b0),
    .i_ext_en(1'b0), .o_wire(lvl1));
  fic_pin_keeper k2 (.i_pin_o(o2), .i_pin_oe(oe2), .i_ext(ext_drv),
    .i_ext_en(1'b1), .o_wire(pin2_in));
  // ==========================================================
  // clock
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // ==========================================================
  // helpers
  function automatic logic [18:0] obs(int s);
    case (s)
      0: return 19'(o_reg_rdata);
      1: return o_cfg;
      2: return 19'({o1, oe1});
      3: return 19'({o2, oe2});
      4: return 19'(o_cond_status);
      5: return 19'(o_watermark);
      6: return 19'(o_conversion_trigger);
      7: return 19'(lvl1);
      default: return 19'(oe2);
    endcase
  endfunction
  task automatic check(string nm, logic [18:0] seen, logic [18:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // the driver only notes, apart from the trigger wait; the monitor below does all other comparing
  task automatic note(int s, logic [18:0] e);
    pend.push_back('{s, e});
    -> look;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    if (a >= 8'h28 && a <= 8'h2C)
      sh[a-8'h28] = d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rdall;
    for (int a = 0; a < 5; a++)
    begin
      @(posedge i_mclk) i_reg_addr <= 8'(8'h28 + a);
      tick(2);
      note(0, 19'(sh[a]));
    end
    @(posedge i_mclk) i_reg_addr <= 8'h2D;
    tick(2);
    note(0, 19'(FIC_UNMAPPED_DATA));
  endtask
  function automatic fic_cfg_s cfg_exp(logic [7:0] q, t, f);
    fic_cfg_s c;
    c.queue_mode = fic_qmode_e'(q[1:0]);
    c.store_temperature = q[2];
    c.sample_threshold = {q[3], t};
    c.range = f[7] ? FIC_RANGE_8G : fic_range_e'(f[7:6]);
    c.quarter_rate_filter = f[4];
    c.external_trigger_sampling = f[3];
    c.output_rate_select = (f[2:0] > 3'h4) ? FIC_RATE_400HZ
                                           : fic_rate_e'(f[2:0]);
    return c;
  endfunction
  task automatic cnd(logic [6:0] c);
    @(posedge i_mclk) i_cond <= c;
    tick(2);
  endtask
  // expected pins follow the shadow routes; unrouted pins keep level
  task automatic pins;
    if (sh[2][6:0] != 7'h00)
      l1 = (|(sh[2][6:0] & i_cond)) ^ sh[2][7];
    if (sh[3][6:0] != 7'h00)
      l2 = (|(sh[3][6:0] & i_cond)) ^ sh[3][7];
    note(2, 19'({l1, sh[2][6:0] != 7'h00}));
    note(3, 19'({l2, sh[3][6:0] != 7'h00}));
    note(7, 19'(l1));
  endtask
  task automatic lvl(logic [9:0] v, logic e);
    @(posedge i_mclk) i_queue_level <= v;
    tick(2);
    note(5, 19'(e));
  endtask
  // ==========================================================
  // monitor
  initial
  begin
    fic_note_s n;
    forever
    begin
      @(look);
      while (pend.size() > 0)
      begin
        n = pend.pop_front();
        check($sformatf("sel%0d", n.sel), obs(n.sel), n.exp);
      end
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    i_rst_n <= 1'b0;
    i_reg_wr <= 1'b0;
    i_reg_addr <= 8'h00;
    i_reg_wdata <= 8'h00;
    i_cond <= 7'h00;
    i_queue_level <= 10'h000;
    ext_drv <= 1'b0;
    sh = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h13};
    void'($urandom(41));
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rdall();
    note(1, cfg_exp(8'h00, 8'h80, 8'h13));
    // every mode and rate code, random other bits
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h28, {4'($urandom), 2'($urandom), 2'(i)});
      wr(8'h29, 8'($urandom));
      wr(8'h2A, 8'($urandom));
      wr(8'h2B, 8'($urandom));
      wr(8'h2C, {5'($urandom), 3'(i)});
      wr(8'h2D, 8'($urandom));
      rdall();
      note(1, cfg_exp(sh[0], sh[1], sh[4]));
    end
    // watermark at a nine-bit threshold of 261
    wr(8'h28, 8'h0A);
    wr(8'h29, 8'h05);
    lvl(10'h104, 1'b0);
    lvl(10'h105, 1'b1);
    wr(8'h28, 8'h08);
    lvl(10'h12C, 1'b0);
    // routing per position, both pins, both polarities
    wr(8'h2C, 8'h13);
    for (int b = 0; b < 7; b++)
    begin
      wr(8'h2A, 8'(1 << b));
      wr(8'h2B, 8'(8'h80 | (1 << b)));
      cnd(7'(1 << b));
      pins();
      cnd(~7'(1 << b));
      pins();
      note(4, 19'(i_cond));
    end
    wr(8'h2A, 8'h83);
    cnd(7'h02);
    pins();
    cnd(7'h00);
    pins();
    wr(8'h2A, 8'h00);
    cnd(7'h7F);
    pins();
    note(4, 19'h7F);
    // external trigger from the second pin
    wr(8'h2B, 8'h01);
    wr(8'h2C, 8'h1B);
    tick(2);
    note(8, 19'h0);
    @(posedge i_mclk) ext_drv <= 1'b1;
    for (k = 0; k < 4 && o_conversion_trigger !== 1'b1; k++)
      tick(1);
    if (k == 4)
    begin
      failures++;
      final_report();
    end
    note(6, 19'h1);
    tick(1);
    note(6, 19'h0);
    tick(2);
    final_report();
  end
endmodule // fifo_intmap_filter_config_tb
